// >>> rtl/hpb_defs.svh
// Constants for the host parallel bus port: pin positions, strap levels and timing counts.
`ifndef HPB_DEFS_SVH
`define HPB_DEFS_SVH

// Positions in the synchronised pin vector.
`define HPB_PINS_W         15
`define HPB_P_D0           0
`define HPB_P_D7           7
`define HPB_P_A0           8
`define HPB_P_A1           9
`define HPB_P_A2           10
`define HPB_P_WR           11
`define HPB_P_RD           12
`define HPB_P_CS           13
`define HPB_P_SPD          14

// Pull-ups make every pin read high until it is first sampled.
`define HPB_PINS_RST       15'h7FFF

`define HPB_STYLE_SEPARATE 1'b0
`define HPB_STYLE_DIRSTRB  1'b1
`define HPB_MUX_LEVEL      1'b0
`define HPB_FAST_LEVEL     1'b0
`define HPB_STROBE_ACTIVE  1'b0
`define HPB_DIR_WRITE      1'b0
`define HPB_IRQ_ACTIVE     1'b0
`define HPB_IRQ_IDLE       1'b1

// Settle count that must be reached, with the strobe steady, before an access is acted upon.
`define HPB_SETTLE_NORMAL  3'h2
`define HPB_SETTLE_FAST    3'h0
// Cycles after reset release before straps are caught; covers the synchroniser depth.
`define HPB_STRAP_WAIT     3'h4
`define HPB_CNT_ONE        3'h1

`endif

// >>> rtl/hpb_pkg.sv
// Types shared by the host parallel bus port.
`include "hpb_defs.svh"

package hpb_pkg;

   typedef enum logic [2:0] {
      HPB_STRAP,
      HPB_IDLE,
      HPB_SETTLE,
      HPB_WRITE,
      HPB_READ
   } hpb_state_t;

   typedef struct packed {
      hpb_state_t              state;
      logic [`HPB_PINS_W-1:0]  s1;
      logic [`HPB_PINS_W-1:0]  s2;
      logic [`HPB_PINS_W-1:0]  s3;
      logic [`HPB_PINS_W-1:0]  flt;
      logic [2:0]              cnt;
      logic                    muxed;
      logic                    fast;
      logic                    style;
      logic [2:0]              addr_lat;
      logic [7:0]              wdata;
      logic [2:0]              reg_addr;
      logic [7:0]              reg_wdata;
      logic                    reg_wr;
      logic                    reg_rd;
      logic [7:0]              dout;
      logic                    doe;
      logic                    irq_n;
   } hpb_st_t;

endpackage : hpb_pkg

// >>> rtl/hpb_port.sv
// Host parallel bus port: strobe decode, address capture, read drive and interrupt pin.
`include "hpb_defs.svh"

module hpb_port
   import hpb_pkg::*;
(
   // Clock and hardware reset.
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   // Host address and strap pins.
   input  wire logic       lowaddr_or_muxed_strap_i,
   input  wire logic       middle_address_bit_i,
   input  wire logic       highaddr_or_latch_strobe_i,
   // Host data bus, split into input, output and enable.
   input  wire logic [7:0] bus_data_i,
   output logic      [7:0] bus_data_o,
   output logic            bus_data_oe_o,
   // Host control pins.
   input  wire logic       write_or_transfer_sense_i,
   input  wire logic       read_or_data_qualifier_i,
   input  wire logic       device_select_n_i,
   input  wire logic       access_speed_select_i,
   output logic            irq_out_n_o,
   // Strobe style from configuration logic on this clock.
   input  wire logic       strobe_style_i,
   // Core register side.
   output logic      [2:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       irq_pending_i
);

   hpb_st_t                st_ff;
   hpb_st_t                nxt_st;
   logic [`HPB_PINS_W-1:0] pins;
   logic [`HPB_PINS_W-1:0] nxt_flt;
   logic                   acc_wr;
   logic                   acc_rd;
   logic                   sel;

   // Returns {write, read}; both low when no transfer is qualified.
   function automatic logic [1:0] hpb_decode(input logic style, input logic wr_pin, input logic rd_pin);
      logic [1:0] r;
      r = 2'h0;
      if (style == `HPB_STYLE_SEPARATE) begin
         // A write and read strobe held low together is illegal and is ignored.
         if ((wr_pin == `HPB_STROBE_ACTIVE) && (rd_pin != `HPB_STROBE_ACTIVE)) begin
            r = 2'h2;
         end
         if ((rd_pin == `HPB_STROBE_ACTIVE) && (wr_pin != `HPB_STROBE_ACTIVE)) begin
            r = 2'h1;
         end
      end else begin
         if (rd_pin == `HPB_STROBE_ACTIVE) begin
            r = (wr_pin == `HPB_DIR_WRITE) ? 2'h2 : 2'h1;
         end
      end
      return r;
   endfunction : hpb_decode

   assign pins = {access_speed_select_i, device_select_n_i, read_or_data_qualifier_i,
                  write_or_transfer_sense_i, highaddr_or_latch_strobe_i, middle_address_bit_i,
                  lowaddr_or_muxed_strap_i, bus_data_i};

   // A pin change is accepted only once the second and third stages agree.
   genvar gi;
   generate
      for (gi = 0; gi < `HPB_PINS_W; gi++) begin : g_flt
         assign nxt_flt[gi] = (st_ff.s2[gi] == st_ff.s3[gi]) ? st_ff.s3[gi] : st_ff.flt[gi];
      end
   endgenerate

   assign {acc_wr, acc_rd} = hpb_decode(st_ff.style, st_ff.flt[`HPB_P_WR], st_ff.flt[`HPB_P_RD]);
   assign sel = (st_ff.flt[`HPB_P_CS] == `HPB_STROBE_ACTIVE);

   always_comb begin
      nxt_st        = st_ff;
      nxt_st.s1     = pins;
      nxt_st.s2     = st_ff.s1;
      nxt_st.s3     = st_ff.s2;
      nxt_st.flt    = nxt_flt;
      nxt_st.reg_wr = 1'b0;
      nxt_st.reg_rd = 1'b0;
      nxt_st.irq_n  = irq_pending_i ? `HPB_IRQ_ACTIVE : `HPB_IRQ_IDLE;
      // Latch enable is sampled regardless of select, as the host may strobe it for other devices.
      if (st_ff.muxed && st_ff.flt[`HPB_P_A2]) begin
         nxt_st.addr_lat = st_ff.flt[`HPB_P_D0 +: 3];
      end
      case (st_ff.state)
         HPB_STRAP: begin
            nxt_st.cnt = st_ff.cnt + `HPB_CNT_ONE;
            if (st_ff.cnt == `HPB_STRAP_WAIT) begin
               nxt_st.muxed = (st_ff.flt[`HPB_P_A0] == `HPB_MUX_LEVEL);
               // Fast timing is refused on a multiplexed bus; the pull-up reset value means normal.
               nxt_st.fast  = (st_ff.flt[`HPB_P_SPD] == `HPB_FAST_LEVEL) &&
                              (st_ff.flt[`HPB_P_A0] != `HPB_MUX_LEVEL);
               nxt_st.style = strobe_style_i;
               nxt_st.state = HPB_IDLE;
            end
         end
         HPB_IDLE: begin
            nxt_st.doe = 1'b0;
            nxt_st.cnt = 3'h0;
            if (sel && (acc_wr || acc_rd)) begin
               nxt_st.state = HPB_SETTLE;
            end
         end
         HPB_SETTLE: begin
            if (!sel || !(acc_wr || acc_rd)) begin
               nxt_st.state = HPB_IDLE;
            end else if (st_ff.cnt >= (st_ff.fast ? `HPB_SETTLE_FAST : `HPB_SETTLE_NORMAL)) begin
               nxt_st.reg_addr = st_ff.muxed ? st_ff.addr_lat
                                             : st_ff.flt[`HPB_P_A2:`HPB_P_A0];
               if (acc_wr) begin
                  nxt_st.wdata = st_ff.flt[`HPB_P_D7:`HPB_P_D0];
                  nxt_st.state = HPB_WRITE;
               end else begin
                  nxt_st.reg_rd = 1'b1;
                  nxt_st.state  = HPB_READ;
               end
            end else begin
               nxt_st.cnt = st_ff.cnt + `HPB_CNT_ONE;
            end
         end
         HPB_WRITE: begin
            // Data is taken at the trailing edge of the strobe, where hosts guarantee it valid.
            if (sel && acc_wr) begin
               nxt_st.wdata = st_ff.flt[`HPB_P_D7:`HPB_P_D0];
            end else begin
               nxt_st.reg_wr    = 1'b1;
               nxt_st.reg_wdata = st_ff.wdata;
               nxt_st.state     = HPB_IDLE;
            end
         end
         HPB_READ: begin
            if (sel && acc_rd) begin
               nxt_st.dout = reg_rdata_i;
               nxt_st.doe  = 1'b1;
            end else begin
               nxt_st.doe   = 1'b0;
               nxt_st.state = HPB_IDLE;
            end
         end
         default: begin
            nxt_st.state = HPB_IDLE;
         end
      endcase
   end

   // Reset puts every flop at a constant; straps are caught later in the strap state.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ff       <= '0;
         st_ff.state <= HPB_STRAP;
         st_ff.s1    <= `HPB_PINS_RST;
         st_ff.s2    <= `HPB_PINS_RST;
         st_ff.s3    <= `HPB_PINS_RST;
         st_ff.flt   <= `HPB_PINS_RST;
         st_ff.irq_n <= `HPB_IRQ_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus_data_o    = st_ff.dout;
   assign bus_data_oe_o = st_ff.doe;
   assign irq_out_n_o   = st_ff.irq_n;
   assign reg_addr_o    = st_ff.reg_addr;
   assign reg_wdata_o   = st_ff.reg_wdata;
   assign reg_wr_o      = st_ff.reg_wr;
   assign reg_rd_o      = st_ff.reg_rd;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   property p_irq_level;
      1'b1 |=> (irq_out_n_o == !$past(irq_pending_i));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("Interrupt pin does not follow pending level.");

   property p_deselect_quiet;
      st_ff.flt[`HPB_P_CS] |=> (!reg_rd_o && !bus_data_oe_o);
   endproperty
   a_deselect_quiet: assert property (p_deselect_quiet) else $error("Access answered while deselected.");

   property p_plain_addr;
      (reg_rd_o && !st_ff.muxed) |-> (reg_addr_o == $past(st_ff.flt[`HPB_P_A2:`HPB_P_A0]));
   endproperty
   a_plain_addr: assert property (p_plain_addr) else $error("Address not taken from address pins.");

   property p_muxed_addr;
      (reg_rd_o && st_ff.muxed) |-> (reg_addr_o == $past(st_ff.addr_lat));
   endproperty
   a_muxed_addr: assert property (p_muxed_addr) else $error("Address not taken from latched bus lines.");

   property p_sep_write;
      (reg_wr_o && (st_ff.style == `HPB_STYLE_SEPARATE)) |-> ($past(st_ff.flt[`HPB_P_WR], 2) == 1'b0);
   endproperty
   a_sep_write: assert property (p_sep_write) else $error("Write issued without a low write strobe.");

   property p_sep_read_drive;
      (bus_data_oe_o && (st_ff.style == `HPB_STYLE_SEPARATE)) |-> ($past(st_ff.flt[`HPB_P_RD]) == 1'b0);
   endproperty
   a_sep_read_drive: assert property (p_sep_read_drive) else $error("Bus driven without a low read strobe.");

   property p_dir_read;
      (reg_rd_o && (st_ff.style == `HPB_STYLE_DIRSTRB)) |-> ($past(st_ff.flt[`HPB_P_WR]) == 1'b1);
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("Read issued with direction set to write.");

   property p_dir_write;
      (reg_wr_o && (st_ff.style == `HPB_STYLE_DIRSTRB)) |-> ($past(st_ff.flt[`HPB_P_RD], 2) == 1'b0);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("Write issued without a low data strobe.");

   property p_fast_plain_only;
      st_ff.muxed |-> !st_ff.fast;
   endproperty
   a_fast_plain_only: assert property (p_fast_plain_only) else $error("Fast timing on a multiplexed bus.");

   property p_normal_settle;
      (reg_rd_o && !st_ff.fast) |-> $past(st_ff.state == HPB_SETTLE, 3);
   endproperty
   a_normal_settle: assert property (p_normal_settle) else $error("Normal timing read acted too early.");

endmodule : hpb_port

// >>> testbench/hpb_host_model.sv
// Behavioural host processor that drives the parallel bus pins of the port.
module hpb_host_model (
   // Clock, configuration and bus view.
   input  wire logic       clk_i,
   input  wire logic       style_i,
   input  wire logic       muxed_i,
   input  wire logic       fast_i,
   input  wire logic       bus_oe_i,
   input  wire logic [7:0] bus_i,
   // Pins driven by the host.
   output logic            cs_n_o,
   output logic            a0_o,
   output logic            a1_o,
   output logic            a2_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic            spd_o,
   output logic            host_oe_o,
   output logic      [7:0] host_d_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // An undriven speed strap reads high through its pull-up, so only fast mode pulls it low.
   assign spd_o = fast_i ? 1'b0 : 1'b1;

   initial begin
      cs_n_o    = 1'b1;
      {a2_o, a1_o, a0_o} = 3'h0;
      wr_o      = 1'b1;
      rd_o      = 1'b1;
      host_oe_o = 1'b0;
      host_d_o  = 8'h00;
   end

   // The port catches its straps only after reset, so the strap pins must sit at their levels before release.
   task automatic park(input logic mx);
      cs_n_o    = 1'b1;
      a0_o      = !mx;
      a1_o      = 1'b1;
      a2_o      = 1'b0;
      wr_o      = 1'b1;
      rd_o      = 1'b1;
      host_oe_o = 1'b0;
   endtask : park

   // One access; the strobe is held twelve cycles so that it outlasts the settle filter.
   task automatic access(input logic sel_n, input logic we, input logic [2:0] a, input logic [7:0] wd,
                         output logic [7:0] rd, output int lat);
      int n;
      rd  = 8'hFF;
      lat = 0;
      @(negedge clk_i);
      cs_n_o = sel_n;
      if (muxed_i) begin
         // The upper lines carry a nonzero pattern during the address phase.
         {a1_o, a0_o} = 2'h2;
         host_oe_o = 1'b1;
         host_d_o  = {5'h15, a};
         a2_o      = 1'b1;
         repeat (6) @(negedge clk_i);
         a2_o = 1'b0;
      end else begin
         {a2_o, a1_o, a0_o} = a;
      end
      host_oe_o = we;
      host_d_o  = wd;
      @(negedge clk_i);
      wr_o = !we;
      rd_o = style_i ? 1'b0 : we;
      for (n = 1; n <= 12; n++) begin
         @(negedge clk_i);
         if (!we && bus_oe_i && lat == 0) begin
            lat = n;
            rd  = bus_i;
         end
      end
      wr_o      = 1'b1;
      rd_o      = 1'b1;
      host_oe_o = 1'b0;
      cs_n_o    = 1'b1;
      if (!muxed_i) begin
         {a2_o, a1_o, a0_o} = ~a;
      end
      repeat (6) @(negedge clk_i);
   endtask : access
endmodule : hpb_host_model

// >>> testbench/host_parallel_bus_port_test.sv
// Self-checking bench for the host parallel bus port.
module host_parallel_bus_port_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic style = 1'b0, muxed = 1'b0, fast = 1'b0, irq_pending = 1'b0;
   logic cs_n, a0, a1, a2, wr, rd, spd, host_oe, dut_oe, irq_n, reg_wr, reg_rd;
   logic [7:0] host_d, dut_d, bus, reg_wdata, wr_d;
   logic [2:0] reg_addr, wr_a;
   int num_errors = 0, compares = 0, wr_cnt = 0, lat_norm, lat_fast, lat_mux;

   always #2.5 core_clk_i = ~core_clk_i;
   // Data lines have pull-ups, so a released bus reads all ones.
   assign bus = dut_oe ? dut_d : (host_oe ? host_d : 8'hFF);

   hpb_port dut_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .lowaddr_or_muxed_strap_i(a0),
      .middle_address_bit_i(a1), .highaddr_or_latch_strobe_i(a2), .bus_data_i(bus), .bus_data_o(dut_d),
      .bus_data_oe_o(dut_oe), .write_or_transfer_sense_i(wr), .read_or_data_qualifier_i(rd),
      .device_select_n_i(cs_n), .access_speed_select_i(spd), .irq_out_n_o(irq_n), .strobe_style_i(style),
      .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_rdata_i(8'hA5 ^ {5'h00, reg_addr}), .irq_pending_i(irq_pending));

   hpb_host_model host_u (.clk_i(core_clk_i), .style_i(style), .muxed_i(muxed), .fast_i(fast),
      .bus_oe_i(dut_oe), .bus_i(bus), .cs_n_o(cs_n), .a0_o(a0), .a1_o(a1), .a2_o(a2), .wr_o(wr),
      .rd_o(rd), .spd_o(spd), .host_oe_o(host_oe), .host_d_o(host_d));

   always @(posedge core_clk_i) begin
      if (reg_wr === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
         wr_a   <= reg_addr;
         wr_d   <= reg_wdata;
      end
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : check

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   // Straps are caught only after reset, so each mode needs a fresh reset.
   task automatic restart(input logic st, input logic mx, input logic fs);
      @(negedge core_clk_i);
      reset_n_i = 1'b0;
      style = st;
      muxed = mx;
      fast  = fs;
      host_u.park(mx);
      repeat (20) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      repeat (12) @(negedge core_clk_i);
   endtask : restart

   // Write then read; the write address and the upper data bits differ from the address bits.
   task automatic t_rw(input string name, output int lat);
      logic [7:0] rdv;
      int n0, l0;
      n0 = wr_cnt;
      host_u.access(1'b0, 1'b1, 3'h5, 8'hE3, rdv, l0);
      check("write pulses", 8'h01, 8'(wr_cnt - n0));
      check("write address", 8'h05, {5'h00, wr_a});
      check("write data", 8'hE3, wr_d);
      host_u.access(1'b0, 1'b0, 3'h2, 8'h00, rdv, lat);
      check("read data", 8'hA5 ^ 8'h02, rdv);
      $display("Test %s done", name);
   endtask : t_rw

   task automatic t_irq;
      @(negedge core_clk_i);
      irq_pending = 1'b1;
      repeat (2) @(negedge core_clk_i);
      check("irq pending", 8'h00, {7'h00, irq_n});
      irq_pending = 1'b0;
      repeat (2) @(negedge core_clk_i);
      check("irq idle", 8'h01, {7'h00, irq_n});
      $display("Test irq done");
   endtask : t_irq

   task automatic t_cs_ignored;
      logic [7:0] rdv;
      int n0, l0;
      n0 = wr_cnt;
      host_u.access(1'b1, 1'b1, 3'h3, 8'h5A, rdv, l0);
      check("write without select", 8'h00, 8'(wr_cnt - n0));
      host_u.access(1'b1, 1'b0, 3'h3, 8'h00, rdv, l0);
      check("read without select", 8'h00, 8'(l0));
      $display("Test select done");
   endtask : t_cs_ignored

   task automatic t_reset;
      @(negedge core_clk_i);
      irq_pending = 1'b1;
      repeat (3) @(negedge core_clk_i);
      reset_n_i = 1'b0;
      @(negedge core_clk_i);
      check("irq in reset", 8'h01, {7'h00, irq_n});
      check("drive in reset", 8'h00, {7'h00, dut_oe});
      irq_pending = 1'b0;
      restart(1'b0, 1'b0, 1'b0);
      $display("Test reset done");
   endtask : t_reset

   initial begin
      restart(1'b0, 1'b0, 1'b0);
      t_irq();
      t_rw("separate", lat_norm);
      t_cs_ignored();
      t_reset();
      t_rw("after reset", lat_norm);
      restart(1'b1, 1'b0, 1'b0);
      t_rw("direction", lat_norm);
      restart(1'b0, 1'b0, 1'b1);
      t_rw("fast", lat_fast);
      check("fast is quicker", 8'h01, {7'h00, lat_fast < lat_norm});
      restart(1'b0, 1'b1, 1'b0);
      t_rw("muxed", lat_mux);
      restart(1'b0, 1'b1, 1'b1);
      t_rw("muxed fast", lat_fast);
      check("fast ignored when muxed", 8'(lat_mux), 8'(lat_fast));
      final_report();
   end

   initial begin
      repeat (20000) @(posedge core_clk_i);
      $display("Error watchdog expected 0 seen 1");
      num_errors++;
      final_report();
   end
endmodule : host_parallel_bus_port_test
